// *** verilog/tki_map.svh ***
// Register map, field positions, reset values and timing counts
`ifndef TKI_MAP_SVH
`define TKI_MAP_SVH
`define TKI_ADDR_HI      5'h11
`define TKI_REG_CFG      8'h00
`define TKI_REG_CHEN     8'h01
`define TKI_REG_KEY      8'h02
`define TKI_REG_CHG      8'h03
`define TKI_REG_IRQ      8'h04
`define TKI_CFG_RST      8'h00
`define TKI_CHEN_RST     8'hff
`define TKI_KEY_RST      8'h00
`define TKI_CHG_RST      8'h00
`define TKI_IRQ_RST      8'h00
`define TKI_SOFT_OFF_BIT 7
`define TKI_SENS_HI      6
`define TKI_SENS_LO      5
`define TKI_AR_HI        7
`define TKI_AR_LO        6
`define TKI_CLK_KHZ      10000
`define TKI_AR_SHORT_MS  8
`define TKI_AR_LONG_MS   32
`endif

// *** verilog/tki_pkg.sv ***
// Types shared by the touch key register interface
package tki_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_IDX  = 5'h04,
    ST_WDAT = 5'h08,
    ST_RDAT = 5'h10
  } tki_i2c_st_t;
  typedef enum logic [1:0] {
    AR_OFF  = 2'h0,
    AR_8MS  = 2'h1,
    AR_32MS = 2'h2,
    AR_BAD  = 2'h3
  } tki_ar_sel_t;
endpackage

// *** verilog/tki_reg_if.sv ***
// Register access strobes between the bus target and the register bank
`timescale 1ns/100ps
interface tki_reg_if;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] index;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport target (output wr_stb, output rd_stb, output index, output wdata, input rdata);
  modport bank   (input wr_stb, input rd_stb, input index, input wdata, output rdata);
endinterface

// *** verilog/tki_strap_decode.sv ***
// Address strap decoder: tells ground, supply, clock line or data line apart
`timescale 1ns/100ps
module tki_strap_decode (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       strap_s,
  input  wire logic       scl_s,
  input  wire logic       sda_s,
  output logic [1:0]      strap_addr_bits
);
  logic [3:0] seen_reg;
  logic [3:0] seen_next;
  logic [1:0] bits_reg;
  logic [1:0] bits_next;
  logic [1:0] arm_reg;
  logic [1:0] arm_next;
  logic       armed;

  // Sticky evidence: high seen, low seen, differs from clock, differs from data.
  // The synchroniser leaves reset at the idle high level, not the real strap level,
  // so evidence is only gathered once two edges have passed its true sample through.
  always_comb begin
    armed = (arm_reg == 2'h2);
    arm_next = armed ? arm_reg : arm_reg + 2'h1;
    seen_next = seen_reg;
    if (armed) begin
      seen_next = seen_reg | {strap_s, ~strap_s, strap_s ^ scl_s, strap_s ^ sda_s};
    end
    if (!seen_next[3]) begin
      bits_next = 2'h0;
    end else if (!seen_next[2]) begin
      bits_next = 2'h3;
    end else if (!seen_next[1]) begin
      bits_next = 2'h1;
    end else begin
      bits_next = 2'h2;
    end
  end

  // A tie to a bus line only shows once that line moves, i.e. at the first start
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_reg <= 4'h0;
      bits_reg <= 2'h0;
      arm_reg  <= 2'h0;
    end else if (clk_en) begin
      seen_reg <= seen_next;
      bits_reg <= bits_next;
      arm_reg  <= arm_next;
    end
  end

  assign strap_addr_bits = bits_reg;
endmodule // tki_strap_decode

// *** verilog/tki_i2c_target.sv ***
// Bus target engine: start/stop detect, address match, index, write and read bytes
`timescale 1ns/100ps
`include "tki_map.svh"
module tki_i2c_target (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       scl_s,
  input  wire logic       sda_s,
  input  wire logic [1:0] strap_addr_bits,
  output logic            sda_oe,
  tki_reg_if.target       rif
);
  tki_pkg::tki_i2c_st_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next, tx_reg, tx_next, idx_reg, idx_next;
  logic       oe_reg, oe_next, rw_flag_reg, rw_flag_next, nack_reg, nack_next;
  logic       scl_q, sda_q, wr_reg, wr_next, rd_reg, rd_next;
  logic       start, stop, rise, fall;

  // Bus events, data only looked at while the clock is high
  assign start = scl_q & scl_s & sda_q & ~sda_s;
  assign stop  = scl_q & scl_s & ~sda_q & sda_s;
  assign rise  = ~scl_q & scl_s;
  assign fall  = scl_q & ~scl_s;

  // Byte engine: shift on clock rise, change our drive on clock fall, and release it at a start or stop
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    idx_next = idx_reg;
    oe_next = oe_reg;
    rw_flag_next = rw_flag_reg;
    nack_next = nack_reg;
    wr_next = 1'b0;
    rd_next = 1'b0;
    if (start) begin
      st_next = tki_pkg::ST_ADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else if (stop) begin
      st_next = tki_pkg::ST_IDLE;
      oe_next = 1'b0;
    end else if (st_reg != tki_pkg::ST_IDLE) begin
      if (rise) begin
        if (cnt_reg < 4'h8) begin
          sh_next = {sh_reg[6:0], sda_s};
          tx_next = {tx_reg[6:0], 1'b0};
          cnt_next = cnt_reg + 4'h1;
        end else if (cnt_reg == 4'h8) begin
          nack_next = sda_s;
          cnt_next = 4'h9;
        end
      end else if (fall) begin
        if (cnt_reg == 4'h8) begin
          unique case (st_reg)
            tki_pkg::ST_ADDR: begin
              if (sh_reg[7:1] == {`TKI_ADDR_HI, strap_addr_bits}) begin
                oe_next = 1'b1;
                rw_flag_next = sh_reg[0];
              end else begin
                st_next = tki_pkg::ST_IDLE;
              end
            end
            tki_pkg::ST_IDX: begin
              idx_next = sh_reg;
              oe_next = 1'b1;
            end
            tki_pkg::ST_WDAT: begin
              wr_next = 1'b1;
              oe_next = 1'b1;
            end
            tki_pkg::ST_RDAT: oe_next = 1'b0;
            tki_pkg::ST_IDLE: oe_next = 1'b0;
          endcase
        end else if (cnt_reg == 4'h9) begin
          cnt_next = 4'h0;
          oe_next = 1'b0;
          unique case (st_reg)
            tki_pkg::ST_ADDR: begin
              if (rw_flag_reg) begin
                st_next = tki_pkg::ST_RDAT;
                tx_next = rif.rdata;
                rd_next = 1'b1;
                oe_next = ~rif.rdata[7];
              end else begin
                st_next = tki_pkg::ST_IDX;
              end
            end
            tki_pkg::ST_IDX:  st_next = tki_pkg::ST_WDAT;
            tki_pkg::ST_WDAT: st_next = tki_pkg::ST_WDAT;
            tki_pkg::ST_RDAT: begin
              if (nack_reg) begin
                st_next = tki_pkg::ST_IDLE;
              end else begin
                tx_next = rif.rdata;
                rd_next = 1'b1;
                oe_next = ~rif.rdata[7];
              end
            end
            tki_pkg::ST_IDLE: st_next = tki_pkg::ST_IDLE;
          endcase
        end else if (st_reg == tki_pkg::ST_RDAT) begin
          oe_next = ~tx_reg[7];
        end
      end
    end
  end

  // State registers; the bus idles high so the edge history starts high
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= tki_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      idx_reg <= 8'h00;
      oe_reg <= 1'b0;
      rw_flag_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else if (clk_en) begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      idx_reg <= idx_next;
      oe_reg <= oe_next;
      rw_flag_reg <= rw_flag_next;
      nack_reg <= nack_next;
      scl_q <= scl_s;
      sda_q <= sda_s;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  assign sda_oe = oe_reg;
  assign rif.wr_stb = wr_reg;
  assign rif.rd_stb = rd_reg;
  assign rif.index = idx_reg;
  assign rif.wdata = sh_reg;
endmodule // tki_i2c_target

// *** verilog/tki_touch_top.sv ***
// Touch key controller digital core: bus target, register bank, key and interrupt logic
`timescale 1ns/100ps
`include "tki_map.svh"
module tki_touch_top #(
  parameter logic [18:0] AR_SHORT_CYC = 19'(`TKI_AR_SHORT_MS * `TKI_CLK_KHZ),
  parameter logic [18:0] AR_LONG_CYC  = 19'(`TKI_AR_LONG_MS * `TKI_CLK_KHZ)
) (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       scl_pin,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       strap_pin,
  input  wire logic       hw_shutdown_n,
  input  wire logic [7:0] key_raw,
  output logic [7:0]      key_out_n,
  output logic            irq_n,
  output logic [1:0]      sens_sel,
  output logic            sense_off
);
  localparam int          NSYNC    = 12;
  localparam logic [11:0] SYNC_RST = 12'h00f;

  logic [NSYNC-1:0] pin_raw, sync1_reg, sync2_reg;
  logic             scl_s, sda_s, strap_s, sdb_s;
  logic [7:0]       key_s;
  logic [1:0]       strap_addr_bits;

  tki_reg_if rif ();

  // Every pin crosses into core_clk through two flip-flops
  assign pin_raw = {key_raw, hw_shutdown_n, strap_pin, sda_in, scl_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      // Pins reset to their idle levels so no false start is seen
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_reg[gi] <= SYNC_RST[gi];
          sync2_reg[gi] <= SYNC_RST[gi];
        end else if (clk_en) begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign scl_s   = sync2_reg[0];
  assign sda_s   = sync2_reg[1];
  assign strap_s = sync2_reg[2];
  assign sdb_s   = sync2_reg[3];
  assign key_s   = sync2_reg[11:4];

  // Strap address decode
  tki_strap_decode u_strap (
    .core_clk        (core_clk),
    .reset_n         (reset_n),
    .clk_en          (clk_en),
    .strap_s         (strap_s),
    .scl_s           (scl_s),
    .sda_s           (sda_s),
    .strap_addr_bits (strap_addr_bits)
  );

  // Bus target engine
  tki_i2c_target u_i2c (
    .core_clk        (core_clk),
    .reset_n         (reset_n),
    .clk_en          (clk_en),
    .scl_s           (scl_s),
    .sda_s           (sda_s),
    .strap_addr_bits (strap_addr_bits),
    .sda_oe          (sda_oe),
    .rif             (rif)
  );

  // Open-drain data line: we only ever pull low
  assign sda_out = 1'b0;

  // Index decode, used by the write path and the read-clear path
  function automatic logic reg_hit(input logic [7:0] idx, input logic [7:0] want);
    reg_hit = (idx == want);
  endfunction

  logic [7:0]  cfg_reg, cfg_next;
  logic [7:0]  chen_reg, chen_next;
  logic [7:0]  key_reg, key_next;
  logic [7:0]  chg_reg, chg_next;
  logic [7:0]  irqc_reg, irqc_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        pend_reg, pend_next;
  logic        off_reg, off_next;
  logic [18:0] tmr_reg, tmr_next;
  logic [7:0]  key_eff, ev;
  logic        shutdown, rd_chg, timeout;
  tki_pkg::tki_ar_sel_t ar_sel;

  // Software writes; read-only and unmapped indices swallow the data
  always_comb begin
    cfg_next = cfg_reg;
    chen_next = chen_reg;
    irqc_next = irqc_reg;
    if (rif.wr_stb) begin
      if (reg_hit(rif.index, `TKI_REG_CFG)) begin
        cfg_next = {rif.wdata[7:5], 5'h00};
      end
      if (reg_hit(rif.index, `TKI_REG_CHEN)) begin
        chen_next = rif.wdata;
      end
      if (reg_hit(rif.index, `TKI_REG_IRQ)) begin
        irqc_next = {rif.wdata[7:6], 6'h00};
      end
    end
  end

  // Key tracking; shutdown freezes the key picture instead of clearing it
  always_comb begin
    shutdown = cfg_reg[`TKI_SOFT_OFF_BIT] | ~sdb_s;
    off_next = shutdown;
    key_eff = key_s & chen_reg;
    key_next = shutdown ? key_reg : key_eff;
    ev = (key_next ^ key_reg) & chen_reg;
    rd_chg = rif.rd_stb & reg_hit(rif.index, `TKI_REG_CHG);
    chg_next = (rd_chg ? 8'h00 : chg_reg) | ev;
  end

  // Interrupt pending with auto release timer; a fresh event beats any clear
  always_comb begin
    ar_sel = tki_pkg::tki_ar_sel_t'(irqc_reg[`TKI_AR_HI:`TKI_AR_LO]);
    unique case (ar_sel)
      tki_pkg::AR_8MS:  timeout = pend_reg & (tmr_reg == AR_SHORT_CYC - 19'h1);
      tki_pkg::AR_32MS: timeout = pend_reg & (tmr_reg == AR_LONG_CYC - 19'h1);
      tki_pkg::AR_OFF:  timeout = 1'b0;
      tki_pkg::AR_BAD:  timeout = 1'b0;           // Invalid code behaves as no release
    endcase
    if (|ev) begin
      pend_next = 1'b1;
      tmr_next = 19'h0;
    end else if (rd_chg | timeout) begin
      pend_next = 1'b0;
      tmr_next = 19'h0;
    end else begin
      pend_next = pend_reg;
      tmr_next = pend_reg ? tmr_reg + 19'h1 : 19'h0;
    end
  end

  // Read data come from a register so the shifter loads a stable byte
  always_comb begin
    unique case (rif.index)
      `TKI_REG_CFG:  rdata_next = cfg_reg;
      `TKI_REG_CHEN: rdata_next = chen_reg;
      `TKI_REG_KEY:  rdata_next = key_reg;
      `TKI_REG_CHG:  rdata_next = chg_reg;
      `TKI_REG_IRQ:  rdata_next = irqc_reg;
      default:       rdata_next = 8'h00;
    endcase
  end

  // Register bank and interrupt state
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= `TKI_CFG_RST;
      chen_reg <= `TKI_CHEN_RST;
      key_reg <= `TKI_KEY_RST;
      chg_reg <= `TKI_CHG_RST;
      irqc_reg <= `TKI_IRQ_RST;
      rdata_reg <= 8'h00;
      pend_reg <= 1'b0;
      off_reg <= 1'b0;
      tmr_reg <= 19'h0;
    end else if (clk_en) begin
      cfg_reg <= cfg_next;
      chen_reg <= chen_next;
      key_reg <= key_next;
      chg_reg <= chg_next;
      irqc_reg <= irqc_next;
      rdata_reg <= rdata_next;
      pend_reg <= pend_next;
      off_reg <= off_next;
      tmr_reg <= tmr_next;
    end
  end

  assign rif.rdata = rdata_reg;
  assign key_out_n = ~key_reg;
  assign irq_n     = ~pend_reg;
  assign sens_sel  = cfg_reg[`TKI_SENS_HI:`TKI_SENS_LO];
  assign sense_off = off_reg;
endmodule // tki_touch_top

// *** verif/tki_host_model.sv ***
// Bus controller model that drives the link as the host would
`timescale 1ns/100ps
module tki_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Idle bus: clock high, data left to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Bit out: data set mid low phase and held through the high phase
  task automatic put_bit(input logic b);
    sda_low = ~b;
    #200 scl = 1'b1;
    #400 scl = 1'b0;
    #200;
  endtask
  // Bit in: line released, sampled mid high phase
  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    #200 scl = 1'b1;
    #200 b = sda;
    #200 scl = 1'b0;
    #200;
  endtask
  // Start or repeated start: data falls with the clock high
  task automatic start();
    sda_low = 1'b0;
    #200 scl = 1'b1;
    #400 sda_low = 1'b1;
    #400 scl = 1'b0;
    #200;
  endtask
  // Stop: data rises with the clock high, bus left idle
  task automatic stop();
    sda_low = 1'b1;
    #200 scl = 1'b1;
    #400 sda_low = 1'b0;
    #400;
  endtask
  // Byte out top bit first, then the acknowledge slot
  task automatic send(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    ack = ~a;
  endtask
  // Write: address with flag 0, index, data; a missing address acknowledge abandons
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] i,
                        input logic [7:0] d, output logic ok);
    logic k;
    k = 1'b1;
    start();
    send({a, 1'b0}, ok);
    if (ok) begin
      send(i, k);
      send(d, ok);
    end
    ok = ok & k;
    stop();
  endtask
  // Read: index written, repeated start, flag 1, one byte left unacknowledged
  task automatic reg_rd(input logic [6:0] a, input logic [7:0] i,
                        output logic [7:0] d, output logic ok);
    logic k;
    d = 8'h00;
    start();
    send({a, 1'b0}, ok);
    if (ok) begin
      send(i, k);
      start();
      send({a, 1'b1}, ok);
      if (ok) begin
        for (int b = 7; b >= 0; b--) get_bit(d[b]);
        put_bit(1'b1);
      end
      ok = ok & k;
    end
    stop();
  endtask
endmodule // tki_host_model

// *** verif/tki_touch_chk.sv ***
// Port checker for the touch key controller core
`timescale 1ns/100ps
module tki_touch_chk #(
  parameter logic [18:0] AR_SHORT_CYC = 19'h13880,
  parameter logic [18:0] AR_LONG_CYC  = 19'h4e200
) (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       scl_pin,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       hw_shutdown_n,
  input wire logic [7:0] key_raw,
  input wire logic [7:0] key_out_n,
  input wire logic       irq_n,
  input wire logic       sense_off
);
  logic [18:0] low_cnt_reg, low_cnt_next;
  logic [3:0]  scl_age_reg, scl_age_next;
  // Low spell of the interrupt and cycles since the clock was low;
  // the spell count wraps after 52 ms, well past any release setting
  always_comb begin
    low_cnt_next = irq_n ? 19'h00000 : low_cnt_reg + 19'h00001;
    scl_age_next = scl_pin ? scl_age_reg + {3'h0, scl_age_reg != 4'hf} : 4'h0;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt_reg <= 19'h00000;
      scl_age_reg <= 4'h0;
    end else begin
      low_cnt_reg <= low_cnt_next;
      scl_age_reg <= scl_age_next;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Start on the pins, and a pin shutdown held past the synchroniser
  sequence s_start;
    scl_pin && $fell(sda_in);
  endsequence
  sequence s_pin_off;
    !hw_shutdown_n [*4];
  endsequence
  chk_pad_low: assert property (sda_out == 1'b0)
    else $error("data pad value not low");
  chk_oe_low_phase: assert property ($rose(sda_oe) |-> !$past(scl_pin, 2))
    else $error("data pulled outside the clock low phase");
  chk_oe_stands: assert property ($rose(sda_oe) |-> sda_oe [*7])
    else $error("data pull released too early");
  chk_start_quiet: assert property (s_start |=> !sda_oe [*4])
    else $error("data pulled right after a start");
  chk_pin_off: assert property (s_pin_off |-> sense_off)
    else $error("pin shutdown not entered");
  chk_key_cause: assert property (!sense_off && !$past(sense_off, 5)
      |-> (~key_out_n & ~($past(key_raw, 3) | $past(key_raw, 4))) == 8'h00)
    else $error("key output low without a press");
  chk_irq_cause: assert property ($fell(irq_n) |-> ##[0:1] key_out_n != $past(key_out_n))
    else $error("interrupt without a key change");
  chk_irq_release: assert property ($rose(irq_n)
      |-> scl_age_reg < 4'h8 || low_cnt_reg >= AR_SHORT_CYC - 19'h00001)
    else $error("interrupt released without read or timeout");
endmodule // tki_touch_chk

bind tki_touch_top tki_touch_chk #(
  .AR_SHORT_CYC(AR_SHORT_CYC),
  .AR_LONG_CYC(AR_LONG_CYC)
) i_chk (.core_clk, .reset_n, .scl_pin, .sda_in, .sda_out, .sda_oe,
         .hw_shutdown_n, .key_raw, .key_out_n, .irq_n, .sense_off);

// *** verif/tki_touch_top_bench.sv ***
// Self-checking bench for the touch key controller core
`timescale 1ns/100ps
module tki_touch_top_bench;
  typedef struct packed {
    logic       wr;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
    logic [1:0] sens;
  } tki_row_t;
  logic       core_clk, reset_n, hw_shutdown_n, scl, sda_low, sda_oe, sda_out;
  logic       irq_n, sense_off, ok;
  logic [1:0] sens_sel, strap_bits;
  logic [7:0] key_raw, key_out_n, rd_data, n_low;
  int         n_mismatch = 0;
  int         compares = 0;
  wire        sda, strap_pin;
  logic [1:0] ar_code [3] = '{2'h1, 2'h2, 2'h0};
  logic [7:0] ar_len [3] = '{8'h28, 8'ha0, 8'hc8};
  // Reset reads first, then write and read back
  tki_row_t   rows [15] = '{
    {1'b0, 8'h00, 8'h00, 8'h00, 2'h0}, {1'b0, 8'h01, 8'h00, 8'hff, 2'h0},
    {1'b0, 8'h02, 8'h00, 8'h00, 2'h0}, {1'b0, 8'h03, 8'h00, 8'h00, 2'h0},
    {1'b0, 8'h04, 8'h00, 8'h00, 2'h0}, {1'b0, 8'h06, 8'h00, 8'h00, 2'h0},
    {1'b1, 8'h00, 8'h3f, 8'h20, 2'h1}, {1'b1, 8'h00, 8'h5f, 8'h40, 2'h2},
    {1'b1, 8'h00, 8'h7f, 8'h60, 2'h3}, {1'b1, 8'h00, 8'h1f, 8'h00, 2'h0},
    {1'b1, 8'h04, 8'hff, 8'hc0, 2'h0}, {1'b1, 8'h04, 8'h3f, 8'h00, 2'h0},
    {1'b1, 8'h02, 8'hff, 8'h00, 2'h0}, {1'b1, 8'h03, 8'hff, 8'h00, 2'h0},
    {1'b1, 8'h01, 8'h0f, 8'h0f, 2'h0}};
  // Open-drain data line with pull-up; strap joined to the chosen net
  assign sda = ~(sda_low | sda_oe);
  assign strap_pin = strap_bits == 2'h0 ? 1'b0 : strap_bits == 2'h1 ? scl
                   : strap_bits == 2'h2 ? sda : 1'b1;
  tki_touch_top #(.AR_SHORT_CYC(19'h00028), .AR_LONG_CYC(19'h000a0)) i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1), .scl_pin(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap_pin(strap_pin),
    .hw_shutdown_n(hw_shutdown_n), .key_raw(key_raw), .key_out_n(key_out_n),
    .irq_n(irq_n), .sens_sel(sens_sel), .sense_off(sense_off));
  tki_host_model i_host (.scl(scl), .sda_low(sda_low), .sda(sda));
  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic hold(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    hold(6);
    reset_n = 1'b1;
    hold(8);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    i_host.reg_wr({5'h11, strap_bits}, i, d, ok);
    chk_bit(ok, 1'b1);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    i_host.reg_rd({5'h11, strap_bits}, i, rd_data, ok);
    chk_bit(ok, 1'b1);
    chk_byte(rd_data, e);
  endtask
  task automatic test_done();
    $display("Compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence: rows, keys, auto release, shutdown, strap and reset
  initial begin
    reset_n = 1'b0;
    hw_shutdown_n = 1'b1;
    key_raw = 8'h00;
    strap_bits = 2'h0;
    do_reset();
    foreach (rows[k]) begin
      if (rows[k].wr) wr(rows[k].idx, rows[k].wd);
      rd(rows[k].idx, rows[k].exp);
      chk_byte({6'h00, sens_sel}, {6'h00, rows[k].sens});
    end
    $display("Test register rows done");
    key_raw = 8'h81;
    hold(8);
    chk_byte(key_out_n, 8'hfe);
    chk_bit(irq_n, 1'b0);
    rd(8'h02, 8'h01);
    chk_bit(irq_n, 1'b0);
    rd(8'h03, 8'h01);
    chk_bit(irq_n, 1'b1);
    rd(8'h03, 8'h00);
    key_raw = 8'h00;
    hold(8);
    chk_byte(key_out_n, 8'hff);
    rd(8'h03, 8'h01);
    $display("Test keys done");
    // Low spell length per release setting; code 00 must outlast the limit
    foreach (ar_code[c]) begin
      wr(8'h04, {ar_code[c], 6'h00});
      key_raw = key_raw ^ 8'h01;
      n_low = 8'h00;
      while (irq_n !== 1'b0 && n_low != 8'h10) begin
        n_low++;
        hold(1);
      end
      n_low = 8'h00;
      while (irq_n === 1'b0 && n_low != 8'hc8) begin
        n_low++;
        hold(1);
      end
      chk_byte(n_low, ar_len[c]);
      rd(8'h03, 8'h01);
    end
    $display("Test auto release done");
    wr(8'h00, 8'h80);
    chk_bit(sense_off, 1'b1);
    key_raw = 8'h02;
    hold(8);
    chk_byte(key_out_n, 8'hfe);
    chk_bit(irq_n, 1'b1);
    rd(8'h01, 8'h0f);
    rd(8'h00, 8'h80);
    wr(8'h00, 8'h00);
    hw_shutdown_n = 1'b0;
    hold(8);
    chk_bit(sense_off, 1'b1);
    rd(8'h01, 8'h0f);
    hw_shutdown_n = 1'b1;
    key_raw = 8'h00;
    $display("Test shutdown done");
    for (int s = 0; s < 4; s++) begin
      strap_bits = s[1:0];
      do_reset();
      i_host.reg_wr({5'h11, ~strap_bits}, 8'h00, 8'h20, ok);
      chk_bit(ok, 1'b0);
      rd(8'h00, 8'h00);
      rd(8'h01, 8'hff);
    end
    $display("Test strap and reset done");
    test_done();
  end
endmodule // tki_touch_top_bench
